// file: hw/profile_consts.svh
// Constants of the code profiling trace formatter: offsets, fields, resets.
// Assumes inclusion by the formatter and the bench only.
`ifndef PROFILE_CONSTS_SVH
`define PROFILE_CONSTS_SVH

// Register byte addresses.
`define ADDR_CTRL    8'h00
`define ADDR_STAT    8'h04

// Control register fields.
`define CTRL_ARM     0
`define CTRL_PROF    1
`define CTRL_TSEL    2
`define CTRL_ALN_LO  3
`define CTRL_ALN_HI  4
`define CTRL_PINEN   5
`define CTRL_SOFTWARE_TRIGGER_BIT    7
`define CTRL_RESET   8'h00

// Flag positions in the line line_byte_a byte.
`define LINE_BYTE_A_STAMP   6
`define LINE_BYTE_A_BUFOVF  5
`define LINE_BYTE_A_TERM    4

// Timing and field values.
`define STAMP_MAX    16'hFFFF
`define FIELD_EMPTY  32'h0000_0001

// AXI responses.
`define RESP_OKAY    2'b00
`define RESP_SLVERR  2'b10

`endif

// file: hw/profile_pkg.sv
// Types shared by the code profiling trace formatter.
// Assumes the constants header is on the include path.
package profile_pkg;

  // Low nibble of the line line_byte_a byte.
  typedef enum logic [3:0] {
    FMT_START  = 4'b0000,
    FMT_IJUMP  = 4'b0001,
    FMT_FULL   = 4'b0010,
    FMT_VECTOR = 4'b0011,
    FMT_FINAL  = 4'b0111
  } line_fmt_t;

  // Sequencer states.
  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_ARMED = 2'b01,
    SEQ_FINAL = 2'b10
  } seq_state_t;

  // Trace alignment codes of the control register.
  typedef enum logic [1:0] {
    ALIGN_END   = 2'b00,
    ALIGN_BEGIN = 2'b01,
    ALIGN_MID   = 2'b10
  } align_t;

  // Change-of-flow event from the core, one per cycle.
  typedef struct packed {
    logic        branch;
    logic        taken;
    logic        ijump;
    logic        vector;
    logic [23:0] dest;
    logic [8:0]  vec_addr;
  } change_of_flow_t;

endpackage : profile_pkg

// file: hw/code_profile_trace_formatter.sv
// Code profiling trace formatter with line buffer, serial output and
// breakpoint sequencer, reached over AXI4-Lite.
// Assumes aclk is the bus clock and the core gives one flow event a cycle.
//
// The address map and the AXI4-Lite slave port were left to the implementer.
`include "profile_consts.svh"

module code_profile_trace_formatter
  import profile_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int PTR_W = 6
) (
  // Clock and reset.
  input  wire logic            aclk,
  input  wire logic            aresetn,
  // AXI4-Lite slave.
  input  wire logic [7:0]      awaddr,
  input  wire logic            awvalid,
  output logic                 awready,
  input  wire logic [31:0]     wdata,
  input  wire logic [3:0]      wstrb,
  input  wire logic            wvalid,
  output logic                 wready,
  output logic [1:0]           bresp,
  output logic                 bvalid,
  input  wire logic            bready,
  input  wire logic [7:0]      araddr,
  input  wire logic            arvalid,
  output logic                 arready,
  output logic [31:0]          rdata,
  output logic [1:0]           rresp,
  output logic                 rvalid,
  input  wire logic            rready,
  // Core feed.
  input  wire change_of_flow_t change_of_flow,
  input  wire logic [23:0]     start_pc,
  // Sequencer sources and breakpoint request.
  input  wire logic            comparator_match,
  input  wire logic            external_event_input,
  input  wire logic            trace_done,
  output logic                 breakpoint_req,
  // Profiling link.
  input  wire logic            profile_clk_in,
  output logic                 profile_data_pin,
  output logic                 profile_data_oe
);

  // ****************************************************************
  // Checks and functions
  // ****************************************************************

  // The pointers wrap by overflow, so the depth must be a power of two.
  if (DEPTH != (1 << PTR_W)) begin : g_bad_depth
    $error("DEPTH must equal two to the power PTR_W.");
  end

  // Bytes actually sent for each line format.
  function automatic logic [7:0] byte_mask(input logic [3:0] f);
    unique case (f)
      FMT_START: byte_mask = 8'h0F;
      FMT_FULL:  byte_mask = 8'h1F;
      FMT_FINAL: byte_mask = 8'hDF;
      default:   byte_mask = 8'hFF;
    endcase
  endfunction : byte_mask

  // Next enabled byte above idx; bit 3 says one was found.
  function automatic logic [3:0] next_byte(input logic [7:0] m,
                                           input logic [2:0] idx);
    next_byte = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (i > idx && m[i]) begin
        next_byte = {1'b1, 3'(i)};
      end
    end
  endfunction : next_byte

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ****************************************************************
  // Register slave
  // ****************************************************************

  logic              aw_got_reg;
  logic              w_got_reg;
  logic [7:0]        awaddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic [7:0]        ctrl_reg;
  logic              bufovf_reg;
  logic              prof_active_reg;
  logic              tx_busy_reg;
  logic [PTR_W:0]    pending_reg;
  seq_state_t        seq_reg;
  logic              wr_fire;
  logic              wr_ctrl;
  logic              sw_software_trigger_bit;
  logic              sw_disarm;
  logic              sw_arm;
  logic              disarm_hw;
  logic              ovf_evt;

  assign awready = !aw_got_reg;
  assign wready  = !w_got_reg;
  assign arready = !rvalid;
  assign wr_fire = aw_got_reg && w_got_reg && !bvalid;
  // Writes are dropped while a disarmed unit still sends old lines.
  assign wr_ctrl = wr_fire && awaddr_reg == `ADDR_CTRL && wstrb_reg[0]
                   && !(!ctrl_reg[`CTRL_ARM] && tx_busy_reg);
  assign sw_software_trigger_bit   = wr_ctrl && wdata_reg[`CTRL_SOFTWARE_TRIGGER_BIT];
  assign sw_disarm = wr_ctrl && ctrl_reg[`CTRL_ARM] && !wdata_reg[`CTRL_ARM];
  assign sw_arm    = wr_ctrl && !ctrl_reg[`CTRL_ARM] && wdata_reg[`CTRL_ARM];

  // Address and data are taken in either order and held until paired.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        w_got_reg <= 1'b1;
        wdata_reg <= wdata;
        wstrb_reg <= wstrb;
      end
      if (wr_fire) begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
      end
    end
  end

  // Write response; the status word is read-only.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= `RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= (awaddr_reg == `ADDR_CTRL) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read channel.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= `RESP_OKAY;
      if (araddr == `ADDR_CTRL) begin
        rdata <= {24'h00_0000, ctrl_reg};
      end else if (araddr == `ADDR_STAT) begin
        rdata <= {14'h0000, seq_reg, 1'b0, pending_reg, 4'h0,
                  prof_active_reg, bufovf_reg, tx_busy_reg,
                  ctrl_reg[`CTRL_ARM]};
      end else begin
        rdata <= 32'h0000_0000;
        rresp <= `RESP_SLVERR;
      end
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Control word; a hardware disarm overrides a same-cycle software arm.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= wdata_reg[7:0] & ~(8'h01 << `CTRL_SOFTWARE_TRIGGER_BIT);
      end
      if (disarm_hw) begin
        ctrl_reg[`CTRL_ARM] <= 1'b0;
      end
    end
  end

  // Sticky overflow status; set wins over the clear by a new arm.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bufovf_reg <= 1'b0;
    end else if (ovf_evt) begin
      bufovf_reg <= 1'b1;
    end else if (sw_arm) begin
      bufovf_reg <= 1'b0;
    end
  end

  assign profile_data_oe = ctrl_reg[`CTRL_PINEN];

  // ****************************************************************
  // State sequencer and breakpoints
  // ****************************************************************

  logic   wait_trace;
  logic   final_done;
  align_t align;

  assign align = align_t'(ctrl_reg[`CTRL_ALN_HI:`CTRL_ALN_LO]);
  // Mid alignment falls back to end alignment while profiling.
  assign wait_trace = ctrl_reg[`CTRL_TSEL] && (align == ALIGN_BEGIN
                      || (align == ALIGN_MID && !ctrl_reg[`CTRL_PROF]));
  assign final_done = seq_reg == SEQ_FINAL && (!wait_trace || trace_done);
  assign disarm_hw  = final_done || ovf_evt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_reg <= SEQ_IDLE;
    end else if (ovf_evt || final_done || sw_disarm) begin
      seq_reg <= SEQ_IDLE;
    end else begin
      unique case (seq_reg)
        SEQ_IDLE: begin
          if (sw_software_trigger_bit) begin
            seq_reg <= SEQ_FINAL;
          end else if (sw_arm) begin
            seq_reg <= SEQ_ARMED;
          end
        end
        SEQ_ARMED: begin
          if (comparator_match || external_event_input || sw_software_trigger_bit) begin
            seq_reg <= SEQ_FINAL;
          end
        end
        SEQ_FINAL: seq_reg <= SEQ_FINAL;
        default:   seq_reg <= SEQ_IDLE;
      endcase
    end
  end

  // Software disarm alone never reaches this pulse.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      breakpoint_req <= 1'b0;
    end else begin
      breakpoint_req <= final_done || ovf_evt;
    end
  end

  chk_bp_cause: assert property (breakpoint_req |->
    $past(seq_reg == SEQ_FINAL) || $past(ovf_evt))
    else $error("Breakpoint without idle entry cause.");

  // ****************************************************************
  // Line assembly
  // ****************************************************************

  logic [31:0] field_reg;
  logic [15:0] ts_reg;
  logic [31:0] field_shift;
  logic        ev_br;
  logic        ev_ij;
  logic        ev_vec;
  logic        full;
  logic        stamp_ovf;
  logic        term_evt;
  logic        start_wr;
  logic        line_wr;
  logic        core_wr;
  line_fmt_t   fmt;
  logic [63:0] wr_line;
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [63:0] mem [DEPTH];

  assign ev_vec = prof_active_reg && change_of_flow.vector;
  assign ev_ij  = prof_active_reg && change_of_flow.ijump && !ev_vec;
  assign ev_br  = prof_active_reg && change_of_flow.branch && !ev_vec && !ev_ij;
  assign field_shift = {field_reg[30:0], change_of_flow.taken};
  assign full      = ev_br && field_shift[31];
  assign stamp_ovf = prof_active_reg && ts_reg == `STAMP_MAX
                     && !ev_br && !ev_ij && !ev_vec;
  assign term_evt  = prof_active_reg && (sw_disarm || final_done);
  assign core_wr   = ev_vec || ev_ij || full || stamp_ovf || term_evt;
  assign ovf_evt   = core_wr && pending_reg == (PTR_W+1)'(DEPTH - 1);
  assign start_wr  = sw_arm && wdata_reg[`CTRL_PROF] && wdata_reg[`CTRL_TSEL];
  assign line_wr   = start_wr || core_wr;

  // Format choice: a same-cycle vector, indirect jump or filled branch field outranks the final format.
  always_comb begin
    fmt     = FMT_FINAL;
    wr_line = 64'h0;
    if (ev_vec) begin
      fmt = FMT_VECTOR;
    end else if (ev_ij) begin
      fmt = FMT_IJUMP;
    end else if (full) begin
      fmt = FMT_FULL;
    end
    if (start_wr) begin
      wr_line = {32'h0000_0000, start_pc, 4'h0, FMT_START};
    end else begin
      wr_line[3:0]            = fmt;
      wr_line[`LINE_BYTE_A_STAMP]    = stamp_ovf;
      wr_line[`LINE_BYTE_A_BUFOVF]   = ovf_evt;
      wr_line[`LINE_BYTE_A_TERM]     = term_evt;
      wr_line[39:8] = ev_br ? field_shift : field_reg;
      unique case (fmt)
        FMT_VECTOR: wr_line[63:40] = {ts_reg, change_of_flow.vec_addr[8:1]};
        FMT_IJUMP:  wr_line[63:40] = change_of_flow.dest;
        FMT_FINAL:  wr_line[63:40] = {ts_reg, 8'h00};
        default:    wr_line[63:40] = 24'h00_0000;
      endcase
    end
  end

  // Branch field restarts with the lone stop marker after every line.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      field_reg <= `FIELD_EMPTY;
    end else if (line_wr) begin
      field_reg <= `FIELD_EMPTY;
    end else if (ev_br) begin
      field_reg <= field_shift;
    end
  end

  // Bus-cycle stamp since the previous entry.
  always_ff @(posedge aclk) begin
    if (!aresetn || line_wr || !prof_active_reg) begin
      ts_reg <= 16'h0000;
    end else begin
      ts_reg <= ts_reg + 16'h0001;
    end
  end

  // Profiling runs from the start line until disarm or overflow.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prof_active_reg <= 1'b0;
    end else if (start_wr) begin
      prof_active_reg <= 1'b1;
    end else if (term_evt || ovf_evt) begin
      prof_active_reg <= 1'b0;
    end
  end

  // Line store; no reset so the storage stays plain flip-flops.
  always_ff @(posedge aclk) begin
    if (line_wr) begin
      mem[wr_ptr_reg] <= wr_line;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_reg <= '0;
    end else if (line_wr) begin
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
  end

  chk_start_line: assert property (start_wr |->
    wr_line[7:0] == 8'h00 && wr_line[31:8] == start_pc)
    else $error("Start line malformed.");
  chk_stamp_clear: assert property (line_wr |=> ts_reg == 16'h0000)
    else $error("Stamp not cleared after a line.");
  chk_full_field: assert property (line_wr && fmt == FMT_FULL && !start_wr
    |-> wr_line[39] && wr_line[3:0] == 4'h2)
    else $error("Full line without marker at top.");
  chk_vector_line: assert property (ev_vec |-> line_wr
    && wr_line[47:40] == change_of_flow.vec_addr[8:1]
    && wr_line[63:48] == ts_reg)
    else $error("Vector line malformed.");
  chk_empty_marker: assert property (ev_ij && field_reg == `FIELD_EMPTY
    |-> wr_line[39:8] == 32'h0000_0001)
    else $error("Empty field marker misplaced.");
  // A disarm or overflow in the same cycle legitimately ends profiling.
  chk_stamp_ovf: assert property (stamp_ovf && !term_evt && !ovf_evt
    |-> line_wr && wr_line[6] ##1 prof_active_reg)
    else $error("Stamp overflow line missing.");
  chk_overflow_stop: assert property (ovf_evt |-> wr_line[5]
    ##1 !prof_active_reg && !ctrl_reg[`CTRL_ARM] && breakpoint_req)
    else $error("Overflow did not stop profiling.");

  // ****************************************************************
  // Serial transmitter
  // ****************************************************************

  logic             clk_s1_reg;
  logic             clk_s2_reg;
  logic             clk_s3_reg;
  logic             clk_lvl_reg;
  logic             link_edge;
  logic [63:0]      tx_line_reg;
  logic [7:0]       tx_mask_reg;
  logic [2:0]       byte_idx_reg;
  logic [2:0]       bit_idx_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [3:0]       nb;
  logic             load;
  logic             tx_done;

  // Link clock is sampled; an edge counts once stages two and three agree.
  // The accepted level resets to the idle low level, so no false edge follows reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_s1_reg  <= 1'b0;
      clk_s2_reg  <= 1'b0;
      clk_s3_reg  <= 1'b0;
      clk_lvl_reg <= 1'b0;
    end else begin
      clk_s1_reg <= profile_clk_in;
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
      if (clk_s2_reg == clk_s3_reg) begin
        clk_lvl_reg <= clk_s3_reg;
      end
    end
  end

  assign link_edge = (clk_s2_reg == clk_s3_reg) && (clk_s3_reg != clk_lvl_reg);
  assign nb        = next_byte(tx_mask_reg, byte_idx_reg);
  // A line is only fetched in a cycle with no new write.
  assign load    = !tx_busy_reg && pending_reg != '0 && !line_wr;
  assign tx_done = tx_busy_reg && link_edge && bit_idx_reg == 3'h7 && !nb[3];

  // Either link edge advances one bit, least significant first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_busy_reg      <= 1'b0;
      tx_line_reg      <= 64'h0;
      tx_mask_reg      <= 8'h00;
      byte_idx_reg     <= 3'h0;
      bit_idx_reg      <= 3'h0;
      rd_ptr_reg       <= '0;
      profile_data_pin <= 1'b0;
    end else if (load) begin
      tx_busy_reg      <= 1'b1;
      tx_line_reg      <= mem[rd_ptr_reg];
      tx_mask_reg      <= byte_mask(mem[rd_ptr_reg][3:0]);
      byte_idx_reg     <= 3'h0;
      bit_idx_reg      <= 3'h0;
      rd_ptr_reg       <= rd_ptr_reg + 1'b1;
      profile_data_pin <= mem[rd_ptr_reg][0];
    end else if (tx_busy_reg && link_edge) begin
      if (bit_idx_reg != 3'h7) begin
        bit_idx_reg      <= bit_idx_reg + 3'h1;
        profile_data_pin <= tx_line_reg[{byte_idx_reg, bit_idx_reg + 3'h1}];
      end else if (nb[3]) begin
        byte_idx_reg     <= nb[2:0];
        bit_idx_reg      <= 3'h0;
        profile_data_pin <= tx_line_reg[{nb[2:0], 3'h0}];
      end else begin
        tx_busy_reg <= 1'b0;
      end
    end
  end

  // Lines waiting or in flight.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending_reg <= '0;
    end else begin
      pending_reg <= pending_reg + (PTR_W+1)'(line_wr) - (PTR_W+1)'(tx_done);
    end
  end

  chk_tx_lsb: assert property (load |=> tx_busy_reg
    && profile_data_pin == tx_line_reg[0])
    else $error("First bit sent is not bit zero.");

endmodule : code_profile_trace_formatter

// file: verification/profile_tool_model.sv
// Debug tool model: clocks the profiling link and collects the line bytes.
// Assumes the bench raises run only once lines are queued for output.
module profile_tool_model (
  // Control from the bench.
  input  wire logic run,
  // Profiling link.
  input  wire logic profile_data_pin,
  output logic      profile_clk_in
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] got[$];
  logic [7:0] b;
  int         n;

  // ************
  // Frame capture
  // ************
  // Each bit is taken at the edge that strobes it, least significant first.
  task automatic grab();
    for (int i = 0; i < 8; i++) begin
      b[i] = profile_data_pin;
      profile_clk_in = ~profile_clk_in;
      #200;
    end
    got.push_back(b);
  endtask : grab

  // The clock stands still between frames; the odd offset keeps edges off aclk.
  initial begin
    profile_clk_in = 1'b0;
    #13;
    forever begin
      #400;
      if (run) begin
        grab();
        case (b[3:0])
          4'h0: n = 3;
          4'h2: n = 4;
          4'h7: n = 6;
          default: n = 7;
        endcase
        repeat (n) grab();
      end
    end
  end
endmodule : profile_tool_model

// file: verification/tb.sv
// Bench for the code profiling trace formatter: bus, sequencer, line stream.
// Assumes the tool model clocks the link only while run is high.
`include "profile_consts.svh"

module tb
  import profile_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic            aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, run;
  logic            awready, wready, bvalid, arready, rvalid, breakpoint_req;
  logic            comparator_match, external_event_input, trace_done;
  logic            profile_clk_in, profile_data_pin, profile_data_oe;
  logic [1:0]      bresp, rresp;
  logic [2:0]      ev;
  logic [3:0]      wstrb;
  logic [7:0]      awaddr, araddr;
  logic [23:0]     start_pc;
  logic [31:0]     wdata, rdata;
  change_of_flow_t change_of_flow;
  logic [7:0]      exp_q[$];
  int              n_mismatch, checks_done, n_bp;

  assign {trace_done, external_event_input, comparator_match} = ev;

  code_profile_trace_formatter code_profile_trace_formatter_inst (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .change_of_flow, .start_pc, .comparator_match, .external_event_input,
    .trace_done, .breakpoint_req, .profile_clk_in, .profile_data_pin, .profile_data_oe
  );
  profile_tool_model profile_tool_model_inst (.run, .profile_data_pin, .profile_clk_in);

  // Bus clock.
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // Pulses are counted, so a missing or doubled pulse both show.
  always @(posedge aclk) begin
    if (breakpoint_req === 1'b1) n_bp <= n_bp + 1;
  end

  // ************
  // Shared tasks
  // ************
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      n_mismatch++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask : check

  task automatic print_verdict();
    $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  task automatic timed_out();
    n_mismatch++;
    $display("Error at %0t: wait ran out", $time);
    print_verdict();
  endtask : timed_out

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] want);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        check(bresp, want);
        return;
      end
    end
    timed_out();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] want, input logic [1:0] wr_);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        check(rdata, want);
        check(rresp, wr_);
        return;
      end
    end
    timed_out();
  endtask : rd

  // One flow event as a single-cycle pulse, then one quiet cycle.
  task automatic flow(input logic b, input logic t, input logic j, input logic v);
    @(posedge aclk);
    change_of_flow <= '{b, t, j, v, 24'h123456, 9'h1A4};
    @(posedge aclk);
    change_of_flow <= '0;
  endtask : flow

  task automatic pulse(input logic [2:0] m);
    @(posedge aclk);
    ev <= m;
    @(posedge aclk);
    ev <= 3'h0;
    repeat (8) @(posedge aclk);
  endtask : pulse

  task automatic push_field(input logic [31:0] f);
    for (int i = 0; i < 4; i++) exp_q.push_back(f[8*i +: 8]);
  endtask : push_field

  task automatic seg(input int a, input int b);
    for (int i = a; i <= b; i++) check(profile_tool_model_inst.got[i], exp_q[i]);
  endtask : seg

  // ************
  // Scenarios
  // ************
  task automatic t_regs();
    rd(`ADDR_CTRL, 32'h0, `RESP_OKAY);
    rd(8'h08, 32'h0, `RESP_SLVERR);
    wr(`ADDR_STAT, 32'h1, `RESP_SLVERR);
    rd(`ADDR_STAT, 32'h0, `RESP_OKAY);
  endtask : t_regs

  task automatic t_break();
    int k;
    k = n_bp;
    wr(`ADDR_CTRL, 32'h80, `RESP_OKAY);
    repeat (6) @(posedge aclk);
    check(n_bp - k, 1);
    wr(`ADDR_CTRL, 32'h01, `RESP_OKAY);
    pulse(3'h1);
    check(n_bp - k, 2);
    wr(`ADDR_CTRL, 32'h0D, `RESP_OKAY);
    pulse(3'h2);
    check(n_bp - k, 2);
    pulse(3'h4);
    check(n_bp - k, 3);
    wr(`ADDR_CTRL, 32'h01, `RESP_OKAY);
    wr(`ADDR_CTRL, 32'h00, `RESP_OKAY);
    repeat (6) @(posedge aclk);
    check(n_bp - k, 3);
  endtask : t_break

  // Start, full, indirect jump, vector and final lines, then the stream is read back.
  task automatic t_profile();
    logic [31:0] f;
    int          k;
    k = n_bp;
    wr(`ADDR_CTRL, 32'h27, `RESP_OKAY);
    check(profile_data_oe, 1'b1);
    exp_q = '{8'h00, 8'hEF, 8'hCD, 8'hAB};
    f = 32'h1;
    for (int i = 0; i < 31; i++) begin
      flow(1'b1, i[0] ^ i[2], 1'b0, 1'b0);
      f = {f[30:0], i[0] ^ i[2]};
    end
    exp_q.push_back(8'h02);
    push_field(f);
    f = 32'h1;
    for (int i = 0; i < 3; i++) begin
      flow(1'b1, ~i[0], 1'b0, 1'b0);
      f = {f[30:0], ~i[0]};
    end
    flow(1'b0, 1'b0, 1'b1, 1'b0);
    exp_q.push_back(8'h01);
    push_field(f);
    exp_q = {exp_q, 8'h56, 8'h34, 8'h12};
    flow(1'b0, 1'b0, 1'b0, 1'b1);
    exp_q.push_back(8'h03);
    push_field(32'h1);
    exp_q = {exp_q, 8'hD2, 8'h01, 8'h00};
    wr(`ADDR_CTRL, 32'h26, `RESP_OKAY);
    exp_q.push_back(8'h17);
    push_field(32'h1);
    exp_q = {exp_q, 8'h02, 8'h00};
    repeat (4) @(posedge aclk);
    run <= 1'b1;
    for (int i = 0; i < 6000 && profile_tool_model_inst.got.size() < 32; i++) @(posedge aclk);
    run <= 1'b0;
    if (profile_tool_model_inst.got.size() < 32) timed_out();
    seg(0, 3);
    seg(4, 8);
    seg(9, 16);
    seg(17, 24);
    seg(25, 31);
    check(profile_tool_model_inst.got.size(), 32);
    check(n_bp - k, 0);
  endtask : t_profile

  // A quiet core runs the stamp out once; the queue then drains after disarm.
  task automatic t_stamp();
    wr(`ADDR_CTRL, 32'h27, `RESP_OKAY);
    repeat (65600) @(posedge aclk);
    rd(`ADDR_STAT, 32'h0001_020B, `RESP_OKAY);
    wr(`ADDR_CTRL, 32'h26, `RESP_OKAY);
    exp_q = {exp_q, 8'h00, 8'hEF, 8'hCD, 8'hAB, 8'h47};
    push_field(32'h1);
    exp_q = {exp_q, 8'hFF, 8'hFF};
    run <= 1'b1;
    for (int i = 0; i < 6000 && profile_tool_model_inst.got.size() < 50; i++) @(posedge aclk);
    run <= 1'b0;
    if (profile_tool_model_inst.got.size() < 50) timed_out();
    seg(32, 42);
    check(profile_tool_model_inst.got.size(), 50);
  endtask : t_stamp

  // The link stays still, so lines pile up until the buffer overflows.
  task automatic t_overflow();
    int k;
    k = n_bp;
    wr(`ADDR_CTRL, 32'h27, `RESP_OKAY);
    repeat (63) flow(1'b0, 1'b0, 1'b1, 1'b0);
    repeat (4) @(posedge aclk);
    check(n_bp - k, 1);
    rd(`ADDR_STAT, 32'h0000_4006, `RESP_OKAY);
  endtask : t_overflow

  // Main sequence.
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, run} = 7'h0;
    {awaddr, araddr, wdata, ev} = '0;
    wstrb = 4'hF;
    start_pc = 24'hABCDEF;
    change_of_flow = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_break();
    t_profile();
    t_stamp();
    t_overflow();
    print_verdict();
  end
endmodule : tb
